// [core/ulps_defs.svh]
// Register offsets, field positions, reset values and timing counts of the LPM status block.
`ifndef ULPS_DEFS_SVH
`define ULPS_DEFS_SVH

// ****************************************
// Register map (byte offsets)
// ****************************************
`define ULPS_OFF_CTRL 12'h000
`define ULPS_OFF_STATUS 12'h004
`define ULPS_OFF_IEN 12'h008
`define ULPS_OFF_INFO 12'h00C

// ****************************************
// Control register fields
// ****************************************
`define ULPS_CTRL_EN 0
`define ULPS_CTRL_NAK 1
`define ULPS_CTRL_RWAKE 2
`define ULPS_CTRL_LS_LSB 4
`define ULPS_CTRL_EP_LSB 8
`define ULPS_CTRL_RT_LSB 12
`define ULPS_CTRL_LS_RST 4'h1
`define ULPS_CTRL_RT_RST 4'h0

// ****************************************
// Event flag positions, shared by status and enable registers
// ****************************************
`define ULPS_FLAG_ERROR 0
`define ULPS_FLAG_WAKEUP 1
`define ULPS_FLAG_UNFINISHED 2
`define ULPS_FLAG_ACCEPTED 3
`define ULPS_FLAG_NOT_YET 4
`define ULPS_FLAG_STALLED 5
`define ULPS_FLAG_W 6

// ****************************************
// Info register fields
// ****************************************
`define ULPS_INFO_EP_LSB 0
`define ULPS_INFO_LS_LSB 4
`define ULPS_INFO_RWAKE 8
`define ULPS_INFO_SUSP 9
`define ULPS_INFO_HOST 10

// ****************************************
// Link state and timing
// ****************************************
`define ULPS_LINK_SLEEP_CODE 4'h1
`define ULPS_RETRY_LIMIT 2'h3
`define ULPS_CLK_MHZ 100
`define ULPS_RESUME_BASE_US 50
`define ULPS_RESUME_STEP_US 75
`define ULPS_RESUME_BASE_CYC (`ULPS_RESUME_BASE_US * `ULPS_CLK_MHZ)
`define ULPS_RESUME_STEP_CYC (`ULPS_RESUME_STEP_US * `ULPS_CLK_MHZ)

`endif

// [core/ulps_pkg.sv]
// Types shared by the LPM status block.
package ulps_pkg;

  typedef enum logic [1:0] {
    ULPS_HS_ACK,
    ULPS_HS_NYET,
    ULPS_HS_STALL,
    ULPS_HS_NAK
  } ulps_hs_t;

  typedef enum logic [1:0] {
    ULPS_ST_RUN,
    ULPS_ST_SLEEP,
    ULPS_ST_RESUME
  } ulps_state_t;

endpackage

// [core/ulps_retry.sv]
// Host-side attempt counter that retries a failing LPM request and gives up after the limit.
`include "ulps_defs.svh"

module ulps_retry
  import ulps_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_mode,
  input wire logic send_start,
  input wire logic attempt_fail,
  input wire logic attempt_done,
  output logic retry_req,
  output logic give_up
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic retry_reg;
  logic retry_next;
  logic give_up_reg;
  logic give_up_next;

  always_comb begin
    cnt_next = cnt_reg;
    retry_next = 1'b0;
    give_up_next = 1'b0;
    if (!host_mode || send_start || attempt_done) begin
      cnt_next = 2'h0;
    end else if (attempt_fail) begin
      // A timeout or corrupted answer counts as one failed attempt.
      if (cnt_reg + 2'h1 == `ULPS_RETRY_LIMIT) begin
        give_up_next = 1'b1; // [RQ4]
        cnt_next = 2'h0;
      end else begin
        retry_next = 1'b1; // [RQ4]
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 2'h0;
      retry_reg <= 1'b0;
      give_up_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      retry_reg <= retry_next;
      give_up_reg <= give_up_next;
    end
  end

  assign retry_req = retry_reg;
  assign give_up = give_up_reg;

endmodule

// [core/ulps_top.sv]
// LPM status, event flags and AHB-Lite register slave of a dual-role USB controller.
//
// Functional notes
// RQ1: Device mode: endpoint of last received LPM.
// RQ2: Host mode: endpoint field shows target endpoint.
// RQ3: Host mode: bus error sets error flag.
// RQ4: Host mode: retry; three failures set unfinished.
// RQ5: Host mode: ACK/NYET/STALL answer sets flag.
// RQ6: Device: unsupported state stalls, sets error, captured.
// RQ7: Device: pending transmit data gives NYET, unfinished.
// RQ8: Device: acknowledge enters suspend, sets accepted.
// RQ9: Device: responses disabled give NYET, not-yet flag.
// RQ10: Device: every stalled LPM sets stalled flag.
// RQ11: Leaving LPM low power sets wakeup flag.
// RQ12: Each flag has enable; enabled flags interrupt.
// RQ13: Status read returns and clears all flags.
// RQ14: Link state: host supplies it, device captures.
// RQ15: Device captures link state on every LPM.
// RQ16: Remote wake: host supplies it, device captures.
// RQ17: Host resume length 50 to 1175 us.
// RQ18: Device entering sleep disables further LPM responses.
// RQ19: Suspended: NAK non-LPM only with option set.
// RQ20: Software targets LPM at addresses 1 to 127.
// RQ21: Flags stick until read; enabled OR drives interrupt.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`include "ulps_defs.svh"

module ulps_top
  import ulps_pkg::*;
#(
  parameter int unsigned RESUME_BASE_CYC = `ULPS_RESUME_BASE_CYC,
  parameter int unsigned RESUME_STEP_CYC = `ULPS_RESUME_STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic host_mode,
  input wire logic rx_lpm_valid,
  input wire logic [2:0] rx_lpm_endpoint,
  input wire logic [3:0] rx_lpm_link_state,
  input wire logic rx_lpm_remote_wake,
  input wire logic rx_token_valid,
  input wire logic tx_fifo_pending,
  input wire logic wake_detect,
  output logic reply_valid,
  output ulps_hs_t reply_code,
  output logic lpm_suspended,
  input wire logic host_send_start,
  input wire logic host_tx_error,
  input wire logic host_attempt_fail,
  input wire logic host_resp_valid,
  input wire ulps_hs_t host_resp_code,
  input wire logic host_resume_start,
  output logic host_retry,
  output logic host_resume_drive,
  output logic [2:0] host_endpoint_index_code,
  output logic [3:0] host_link_state,
  output logic host_remote_wake_permit,
  output logic usb_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int FW = `ULPS_FLAG_W;

  logic lpm_enable_reg, lpm_enable_next;
  logic suspend_nak_option_reg, suspend_nak_option_next;
  logic remote_wake_permit_reg, remote_wake_permit_next;
  logic [3:0] link_state_cfg_reg, link_state_cfg_next;
  logic [2:0] endpoint_cfg_reg, endpoint_cfg_next;
  logic [3:0] resume_time_reg, resume_time_next;
  logic [FW-1:0] flags_reg, flags_next;
  logic [FW-1:0] ien_reg, ien_next;
  logic [2:0] cap_endpoint_reg, cap_endpoint_next;
  logic [3:0] cap_link_state_reg, cap_link_state_next;
  logic cap_remote_wake_reg, cap_remote_wake_next;
  logic reply_valid_reg, reply_valid_next;
  ulps_hs_t reply_code_reg, reply_code_next;
  logic dp_write_reg, dp_write_next;
  logic [11:0] dp_addr_reg, dp_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  ulps_state_t state_reg, state_next;
  logic [16:0] resume_cnt_reg, resume_cnt_next;
  logic [FW-1:0] dev_set;
  logic [FW-1:0] host_set;
  logic [FW-1:0] fsm_set;
  logic [FW-1:0] set_vec;
  logic dev_accept;
  logic give_up;
  logic addr_phase;

  // ****************************************
  // Host retry counter
  // ****************************************
  ulps_retry u_retry (
    .clk(clk),
    .sys_rst(sys_rst),
    .host_mode(host_mode),
    .send_start(host_send_start),
    .attempt_fail(host_attempt_fail),
    .attempt_done(host_resp_valid),
    .retry_req(host_retry),
    .give_up(give_up)
  );

  // ****************************************
  // LPM answers and event sources
  // ****************************************
  always_comb begin
    dev_set = '0;
    host_set = '0;
    dev_accept = 1'b0;
    reply_valid_next = 1'b0;
    reply_code_next = reply_code_reg;
    cap_endpoint_next = cap_endpoint_reg;
    cap_link_state_next = cap_link_state_reg;
    cap_remote_wake_next = cap_remote_wake_reg;
    if (!host_mode && rx_lpm_valid) begin
      // The request is captured whatever answer it gets.
      cap_endpoint_next = rx_lpm_endpoint; // [RQ1]
      cap_link_state_next = rx_lpm_link_state; // [RQ14] [RQ15]
      cap_remote_wake_next = rx_lpm_remote_wake; // [RQ16]
      reply_valid_next = 1'b1;
      if (!lpm_enable_reg) begin
        reply_code_next = ULPS_HS_NYET; // [RQ9] [RQ18]
        dev_set[`ULPS_FLAG_NOT_YET] = 1'b1; // [RQ9]
      end else if (rx_lpm_link_state != `ULPS_LINK_SLEEP_CODE) begin
        reply_code_next = ULPS_HS_STALL; // [RQ6]
        dev_set[`ULPS_FLAG_ERROR] = 1'b1; // [RQ6]
        dev_set[`ULPS_FLAG_STALLED] = 1'b1; // [RQ10]
      end else if (tx_fifo_pending) begin
        reply_code_next = ULPS_HS_NYET; // [RQ7]
        dev_set[`ULPS_FLAG_UNFINISHED] = 1'b1; // [RQ7]
      end else begin
        reply_code_next = ULPS_HS_ACK; // [RQ8]
        dev_set[`ULPS_FLAG_ACCEPTED] = 1'b1; // [RQ8]
        dev_accept = 1'b1;
      end
    end else if (!host_mode && rx_token_valid && state_reg == ULPS_ST_SLEEP
                 && suspend_nak_option_reg) begin
      // Without the option a suspended device stays silent.
      reply_valid_next = 1'b1; // [RQ19]
      reply_code_next = ULPS_HS_NAK; // [RQ19]
    end
    if (host_mode) begin
      host_set[`ULPS_FLAG_ERROR] = host_tx_error; // [RQ3]
      host_set[`ULPS_FLAG_UNFINISHED] = give_up; // [RQ4]
      if (host_resp_valid) begin
        host_set[`ULPS_FLAG_ACCEPTED] = host_resp_code == ULPS_HS_ACK; // [RQ5]
        host_set[`ULPS_FLAG_NOT_YET] = host_resp_code == ULPS_HS_NYET; // [RQ5]
        host_set[`ULPS_FLAG_STALLED] = host_resp_code == ULPS_HS_STALL; // [RQ5]
      end
    end
  end

  // ****************************************
  // Power state: suspend and host resume timing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    resume_cnt_next = resume_cnt_reg;
    fsm_set = '0;
    unique case (state_reg)
      ULPS_ST_RUN: begin
        if (host_mode && host_resume_start) begin
          state_next = ULPS_ST_RESUME;
          resume_cnt_next = 17'(RESUME_BASE_CYC + 32'(resume_time_reg) * RESUME_STEP_CYC
                                - 1); // [RQ17]
        end else if (dev_accept) begin
          state_next = ULPS_ST_SLEEP; // [RQ8]
        end
      end
      ULPS_ST_SLEEP: begin
        if (wake_detect || host_mode) begin
          state_next = ULPS_ST_RUN;
          fsm_set[`ULPS_FLAG_WAKEUP] = 1'b1; // [RQ11]
        end
      end
      ULPS_ST_RESUME: begin
        if (resume_cnt_reg == 17'h0) begin
          state_next = ULPS_ST_RUN;
          fsm_set[`ULPS_FLAG_WAKEUP] = 1'b1; // [RQ11]
        end else begin
          resume_cnt_next = resume_cnt_reg - 17'h1; // [RQ17]
        end
      end
      default: begin
        state_next = ULPS_ST_RUN;
      end
    endcase
  end

  assign set_vec = dev_set | host_set | fsm_set;
  assign addr_phase = hsel && htrans[1] && hready;

  // ****************************************
  // Register file and bus slave
  // ****************************************
  always_comb begin
    lpm_enable_next = lpm_enable_reg;
    suspend_nak_option_next = suspend_nak_option_reg;
    remote_wake_permit_next = remote_wake_permit_reg;
    link_state_cfg_next = link_state_cfg_reg;
    endpoint_cfg_next = endpoint_cfg_reg;
    resume_time_next = resume_time_reg;
    ien_next = ien_reg;
    hrdata_next = hrdata_reg;
    dp_write_next = addr_phase && hwrite;
    dp_addr_next = addr_phase ? haddr[11:0] : dp_addr_reg;
    // Hardware auto-disable on acceptance; a write in the same cycle wins.
    if (dev_accept) begin
      lpm_enable_next = 1'b0; // [RQ18]
    end
    if (dp_write_reg && dp_addr_reg == `ULPS_OFF_CTRL) begin
      lpm_enable_next = hwdata[`ULPS_CTRL_EN];
      suspend_nak_option_next = hwdata[`ULPS_CTRL_NAK];
      remote_wake_permit_next = hwdata[`ULPS_CTRL_RWAKE];
      link_state_cfg_next = hwdata[`ULPS_CTRL_LS_LSB +: 4];
      endpoint_cfg_next = hwdata[`ULPS_CTRL_EP_LSB +: 3];
      resume_time_next = hwdata[`ULPS_CTRL_RT_LSB +: 4];
    end
    if (dp_write_reg && dp_addr_reg == `ULPS_OFF_IEN) begin
      ien_next = hwdata[FW-1:0]; // [RQ12]
    end
    // Events of this cycle are merged into the read so a clear never loses one.
    flags_next = flags_reg | set_vec; // [RQ21]
    if (addr_phase && !hwrite) begin
      hrdata_next = 32'h0;
      unique case (haddr[11:0])
        `ULPS_OFF_CTRL: begin
          hrdata_next[`ULPS_CTRL_EN] = lpm_enable_next;
          hrdata_next[`ULPS_CTRL_NAK] = suspend_nak_option_next;
          hrdata_next[`ULPS_CTRL_RWAKE] = remote_wake_permit_next;
          hrdata_next[`ULPS_CTRL_LS_LSB +: 4] = link_state_cfg_next;
          hrdata_next[`ULPS_CTRL_EP_LSB +: 3] = endpoint_cfg_next;
          hrdata_next[`ULPS_CTRL_RT_LSB +: 4] = resume_time_next;
        end
        `ULPS_OFF_STATUS: begin
          hrdata_next[FW-1:0] = flags_reg | set_vec; // [RQ13]
          flags_next = '0; // [RQ13]
        end
        `ULPS_OFF_IEN: begin
          hrdata_next[FW-1:0] = ien_next;
        end
        `ULPS_OFF_INFO: begin
          hrdata_next[`ULPS_INFO_EP_LSB +: 3] = host_mode ? endpoint_cfg_next
                                                          : cap_endpoint_next; // [RQ1] [RQ2]
          hrdata_next[`ULPS_INFO_LS_LSB +: 4] = host_mode ? link_state_cfg_next
                                                          : cap_link_state_next; // [RQ14]
          hrdata_next[`ULPS_INFO_RWAKE] = host_mode ? remote_wake_permit_next
                                                    : cap_remote_wake_next; // [RQ16]
          hrdata_next[`ULPS_INFO_SUSP] = state_reg == ULPS_ST_SLEEP;
          hrdata_next[`ULPS_INFO_HOST] = host_mode;
        end
        default: begin
          hrdata_next = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lpm_enable_reg <= 1'b0;
      suspend_nak_option_reg <= 1'b0;
      remote_wake_permit_reg <= 1'b0;
      link_state_cfg_reg <= `ULPS_CTRL_LS_RST;
      endpoint_cfg_reg <= 3'h0;
      resume_time_reg <= `ULPS_CTRL_RT_RST;
      flags_reg <= '0;
      ien_reg <= '0;
      cap_endpoint_reg <= 3'h0;
      cap_link_state_reg <= 4'h0;
      cap_remote_wake_reg <= 1'b0;
      reply_valid_reg <= 1'b0;
      reply_code_reg <= ULPS_HS_ACK;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0;
      state_reg <= ULPS_ST_RUN;
      resume_cnt_reg <= 17'h0;
    end else begin
      lpm_enable_reg <= lpm_enable_next;
      suspend_nak_option_reg <= suspend_nak_option_next;
      remote_wake_permit_reg <= remote_wake_permit_next;
      link_state_cfg_reg <= link_state_cfg_next;
      endpoint_cfg_reg <= endpoint_cfg_next;
      resume_time_reg <= resume_time_next;
      flags_reg <= flags_next;
      ien_reg <= ien_next;
      cap_endpoint_reg <= cap_endpoint_next;
      cap_link_state_reg <= cap_link_state_next;
      cap_remote_wake_reg <= cap_remote_wake_next;
      reply_valid_reg <= reply_valid_next;
      reply_code_reg <= reply_code_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg <= dp_addr_next;
      hrdata_reg <= hrdata_next;
      state_reg <= state_next;
      resume_cnt_reg <= resume_cnt_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every access completes without wait states and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign reply_valid = reply_valid_reg;
  assign reply_code = reply_code_reg;
  assign lpm_suspended = state_reg == ULPS_ST_SLEEP;
  assign host_resume_drive = state_reg == ULPS_ST_RESUME;
  assign host_endpoint_index_code = endpoint_cfg_reg; // [RQ2]
  assign host_link_state = link_state_cfg_reg; // [RQ14]
  assign host_remote_wake_permit = remote_wake_permit_reg; // [RQ16]
  assign usb_irq = |(flags_reg & ien_reg); // [RQ12] [RQ21]

endmodule

// [bench/ulps_properties.sv]
// Port-level concurrent checks of the LPM status block.
module ulps_properties
  import ulps_pkg::*;
#(
  parameter int unsigned RESUME_BASE_CYC = 5,
  parameter int unsigned RESUME_STEP_CYC = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_mode,
  input wire logic rx_lpm_valid,
  input wire logic [3:0] rx_lpm_link_state,
  input wire logic rx_token_valid,
  input wire logic tx_fifo_pending,
  input wire logic wake_detect,
  input wire logic reply_valid,
  input wire ulps_hs_t reply_code,
  input wire logic lpm_suspended,
  input wire logic host_send_start,
  input wire logic host_attempt_fail,
  input wire logic host_resp_valid,
  input wire logic host_retry,
  input wire logic host_resume_drive
);
  logic [15:0] run_reg, run_next;
  logic [1:0] fail_reg, fail_next;
  // ****
  // Helper counters
  // ****
  always_comb begin
    run_next = host_resume_drive ? run_reg + 16'h0001 : 16'h0000;
    fail_next = fail_reg;
    if (!host_mode || host_send_start || host_resp_valid) begin
      fail_next = 2'h0;
    end else if (host_attempt_fail && fail_reg != 2'h3) begin
      fail_next = fail_reg + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    run_reg <= sys_rst ? 16'h0000 : run_next;
    fail_reg <= sys_rst ? 2'h0 : fail_next;
  end
  // ****
  // Properties
  // ****
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_req; rx_lpm_valid && !host_mode; endsequence
  sequence s_ack; reply_valid && reply_code == ULPS_HS_ACK; endsequence
  sequence s_fail;
    host_mode && host_attempt_fail && !host_send_start && !host_resp_valid;
  endsequence
  a_req_reply: assert property (s_req |=> reply_valid)
    else $error("LPM request not answered");
  a_ack_suspend: assert property (s_ack |-> lpm_suspended)
    else $error("ACK without suspend");
  a_bad_state: assert property (s_req ##0 rx_lpm_link_state != 4'h1
    |=> reply_code inside {ULPS_HS_NYET, ULPS_HS_STALL}) else $error("bad state acknowledged");
  a_fifo_busy: assert property (s_req ##0 tx_fifo_pending
    |=> reply_code inside {ULPS_HS_NYET, ULPS_HS_STALL}) else $error("busy fifo acknowledged");
  a_wake_exit: assert property (lpm_suspended && wake_detect && !rx_lpm_valid
    |=> !lpm_suspended) else $error("wake did not leave suspend");
  a_nak_cause: assert property (reply_valid && reply_code == ULPS_HS_NAK
    |-> $past(rx_token_valid) && $past(lpm_suspended)) else $error("NAK without cause");
  a_retry_early: assert property (s_fail ##0 fail_reg < 2'h2 |=> host_retry)
    else $error("failed attempt not retried");
  a_retry_stop: assert property (s_fail ##0 fail_reg == 2'h2 |=> !host_retry)
    else $error("retry after third failure");
  a_resume_len: assert property ($fell(host_resume_drive) |->
    run_reg >= RESUME_BASE_CYC && (run_reg - RESUME_BASE_CYC) % RESUME_STEP_CYC == 0
    && run_reg <= RESUME_BASE_CYC + 15 * RESUME_STEP_CYC) else $error("resume length wrong");
endmodule

bind ulps_top ulps_properties #(.RESUME_BASE_CYC(RESUME_BASE_CYC),
  .RESUME_STEP_CYC(RESUME_STEP_CYC)) u_props (.clk(clk), .sys_rst(sys_rst),
  .host_mode(host_mode), .rx_lpm_valid(rx_lpm_valid), .rx_lpm_link_state(rx_lpm_link_state),
  .rx_token_valid(rx_token_valid), .tx_fifo_pending(tx_fifo_pending),
  .wake_detect(wake_detect), .reply_valid(reply_valid), .reply_code(reply_code),
  .lpm_suspended(lpm_suspended), .host_send_start(host_send_start),
  .host_attempt_fail(host_attempt_fail), .host_resp_valid(host_resp_valid),
  .host_retry(host_retry), .host_resume_drive(host_resume_drive));

// [bench/ulps_partner.sv]
// Behavioural USB host facing the device role: LPM requests, other tokens and resume.
module ulps_partner (
  input wire logic clk,
  output logic rx_lpm_valid,
  output logic [2:0] rx_lpm_endpoint,
  output logic [3:0] rx_lpm_link_state,
  output logic rx_lpm_remote_wake,
  output logic rx_token_valid,
  output logic wake_detect
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_lpm_valid = 1'b0;
    rx_token_valid = 1'b0;
    wake_detect = 1'b0;
    {rx_lpm_endpoint, rx_lpm_link_state, rx_lpm_remote_wake} = 8'h5A;
  end
  // Qualifiers show their inverse once the strobe drops, so a late sample reads wrong.
  task automatic lpm(input logic [2:0] ep, input logic [3:0] ls, input logic rw);
    @(posedge clk);
    rx_lpm_valid <= 1'b1;
    {rx_lpm_endpoint, rx_lpm_link_state, rx_lpm_remote_wake} <= {ep, ls, rw};
    @(posedge clk);
    rx_lpm_valid <= 1'b0;
    {rx_lpm_endpoint, rx_lpm_link_state, rx_lpm_remote_wake} <= ~{ep, ls, rw};
  endtask
  task automatic pulse(input logic wk);
    @(posedge clk);
    wake_detect <= wk;
    rx_token_valid <= !wk;
    @(posedge clk);
    wake_detect <= 1'b0;
    rx_token_valid <= 1'b0;
  endtask
endmodule

// [bench/ulps_top_tb.sv]
// Self-checking testbench of the LPM status block in device and host roles.
`include "ulps_defs.svh"

module ulps_top_tb
  import ulps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned BASE = 5;
  localparam int unsigned STEP = 3;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, host_mode, tx_fifo_pending, rd_ph, rw;
  logic [31:0] haddr, hwdata, hrdata, rd_q[$];
  logic [1:0] htrans;
  logic [2:0] hsize, ep, host_ep;
  logic [3:0] hp, ls_l, host_ls;
  logic rx_v, rx_rw, rx_tok, wake, reply_valid, susp, host_resp_valid, host_retry;
  logic drive, host_rw, usb_irq;
  logic [2:0] rx_ep;
  logic [3:0] rx_ls;
  ulps_hs_t reply_code, host_resp_code, rep_q[$];
  int mismatches, n_checks, n_retry, w;

  ulps_top #(.RESUME_BASE_CYC(BASE), .RESUME_STEP_CYC(STEP)) dut (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .host_mode(host_mode), .rx_lpm_valid(rx_v), .rx_lpm_endpoint(rx_ep),
    .rx_lpm_link_state(rx_ls), .rx_lpm_remote_wake(rx_rw), .rx_token_valid(rx_tok),
    .tx_fifo_pending(tx_fifo_pending), .wake_detect(wake), .reply_valid(reply_valid),
    .reply_code(reply_code), .lpm_suspended(susp), .host_send_start(hp[2]),
    .host_tx_error(hp[0]), .host_attempt_fail(hp[1]), .host_resp_valid(host_resp_valid),
    .host_resp_code(host_resp_code), .host_resume_start(hp[3]), .host_retry(host_retry),
    .host_resume_drive(drive), .host_endpoint_index_code(host_ep),
    .host_link_state(host_ls), .host_remote_wake_permit(host_rw), .usb_irq(usb_irq));
  ulps_partner fp (.clk(clk), .rx_lpm_valid(rx_v), .rx_lpm_endpoint(rx_ep),
    .rx_lpm_link_state(rx_ls), .rx_lpm_remote_wake(rx_rw), .rx_token_valid(rx_tok),
    .wake_detect(wake));

  // ****
  // Checking and bus tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'($urandom));
  endtask
  task automatic req(input logic [3:0] ls, input ulps_hs_t r);
    ep = 3'($urandom);
    rw = 1'($urandom);
    ls_l = ls;
    rep_q.push_back(r);
    fp.lpm(ep, ls, rw);
    repeat (2) @(posedge clk);
  endtask
  task automatic hpulse(input int i);
    @(posedge clk);
    hp[i] <= 1'b1;
    @(posedge clk);
    hp[i] <= 1'b0;
  endtask
  function automatic logic [31:0] info(input logic s);
    return {21'h000000, host_mode, s, rw, ls_l, 1'b0, ep};
  endfunction
  task automatic done(input string s);
    chk("unanswered replies", 32'h0, 32'(rep_q.size()));
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Results are compared in the order they were noted.
  always @(posedge clk) begin
    if (rd_ph) chk("hrdata", rd_q.pop_front(), hrdata);
    if (rd_ph) chk("hresp", 32'h0, 32'(hresp));
    if (reply_valid === 1'b1) begin
      chk("reply_code", rep_q.size() > 0 ? 32'(rep_q.pop_front()) : 32'hF,
          32'(reply_code));
    end
    if (host_retry === 1'b1) n_retry++;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    mismatches++;
    results();
  end
  initial begin
    {sys_rst, hsel, hwrite, htrans, haddr, hwdata, rd_ph} = {1'b1, 69'h0};
    {host_mode, tx_fifo_pending, hp, host_resp_valid} = 7'h00;
    hsize = 3'h2;
    host_resp_code = ULPS_HS_ACK;
    void'($urandom(32'h031E0B62));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ULPS_OFF_CTRL, 32'h10);
    rd(`ULPS_OFF_STATUS, 32'h0);
    bus(12'h010, 1'b1, 32'($urandom));
    rd(12'h010, 32'h0);
    done("reset");
    bus(`ULPS_OFF_IEN, 1'b1, 32'h3F);
    req(4'h1, ULPS_HS_NYET);
    chk("usb_irq", 32'h1, 32'(usb_irq));
    rd(`ULPS_OFF_INFO, info(1'b0));
    rd(`ULPS_OFF_STATUS, 32'h10);
    rd(`ULPS_OFF_STATUS, 32'h0);
    chk("usb_irq", 32'h0, 32'(usb_irq));
    bus(`ULPS_OFF_CTRL, 1'b1, 32'h11);
    req(4'h2, ULPS_HS_STALL);
    rd(`ULPS_OFF_INFO, info(1'b0));
    rd(`ULPS_OFF_STATUS, 32'h21);
    tx_fifo_pending <= 1'b1;
    req(4'h1, ULPS_HS_NYET);
    tx_fifo_pending <= 1'b0;
    rd(`ULPS_OFF_STATUS, 32'h04);
    done("device answers");
    req(4'h1, ULPS_HS_ACK);
    chk("lpm_suspended", 32'h1, 32'(susp));
    rd(`ULPS_OFF_STATUS, 32'h08);
    rd(`ULPS_OFF_CTRL, 32'h10);
    rd(`ULPS_OFF_INFO, info(1'b1));
    fp.pulse(1'b0);
    repeat (2) @(posedge clk);
    bus(`ULPS_OFF_CTRL, 1'b1, 32'h12);
    rep_q.push_back(ULPS_HS_NAK);
    fp.pulse(1'b0);
    repeat (2) @(posedge clk);
    req(4'h1, ULPS_HS_NYET);
    fp.pulse(1'b1);
    repeat (2) @(posedge clk);
    chk("lpm_suspended", 32'h0, 32'(susp));
    rd(`ULPS_OFF_STATUS, 32'h12);
    bus(`ULPS_OFF_IEN, 1'b1, 32'h08);
    req(4'h1, ULPS_HS_NYET);
    chk("usb_irq", 32'h0, 32'(usb_irq));
    rd(`ULPS_OFF_STATUS, 32'h10);
    done("suspend");
    host_mode <= 1'b1;
    ep = 3'($urandom);
    {rw, ls_l} = 5'h11;
    bus(`ULPS_OFF_CTRL, 1'b1, {16'h0000, 4'h1, 1'b0, ep, 4'h1, 4'h4});
    bus(`ULPS_OFF_IEN, 1'b1, 32'h3F);
    chk("host endpoint", 32'(ep), 32'(host_ep));
    chk("host link state", 32'h1, 32'(host_ls));
    chk("host remote wake", 32'h1, 32'(host_rw));
    rd(`ULPS_OFF_INFO, info(1'b0));
    hpulse(0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      host_resp_valid <= 1'b1;
      host_resp_code <= ulps_hs_t'(i);
      @(posedge clk);
      host_resp_valid <= 1'b0;
    end
    rd(`ULPS_OFF_STATUS, 32'h39);
    n_retry = 0;
    // The request engine is taken to aim at a legal device address of 1 to 127.
    hpulse(2);
    repeat (3) begin
      hpulse(1);
      repeat (3) @(posedge clk);
    end
    chk("host_retry count", 32'h2, 32'(n_retry));
    rd(`ULPS_OFF_STATUS, 32'h04);
    hpulse(3);
    w = 0;
    while (drive !== 1'b1 && w < 20) begin
      @(posedge clk);
      w++;
    end
    w = 0;
    while (drive === 1'b1 && w < 2000) begin
      @(posedge clk);
      w++;
    end
    chk("resume length", BASE + STEP, 32'(w));
    rd(`ULPS_OFF_STATUS, 32'h02);
    done("host");
    results();
  end
endmodule
